// *** rtl/dws_sequencer.sv ***
// Functional notes
// - writing 0100h to 6Fh starts start-up
// - start-up runs index 0 through 22
// - default start-up steps in documented order
// - steps 8,11,18,23,24 are dummy writes
// - both default sequences present after power-up
// - one host write runs whole sequence
// - writing 0119h runs indices 25 to 39
// - steps 25 and 26 short both line outputs first
// - host may reprogram indices 0 to 31
// - user steps survive software reset
// - power-up restores default step contents
// - default start-up takes about 280ms
// - step time 62.5us times (2^delay + 8)
// - end-of-sequence flag stops after step
// - write width+1 bits at lsb, keep others
`timescale 1ns/1ps
`include "dws_map.svh"
module dws_sequencer (
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              host_wr,
    input  wire logic [7:0]        host_addr,
    input  wire logic [15:0]       host_data,
    input  wire logic              step_wr,
    input  wire dws_pkg::dws_index_t step_index,
    input  wire dws_pkg::dws_word_t  step_word,
    input  wire logic [15:0]       target_rdata,
    output logic [7:0]             target_register_index,
    output logic                   target_rd,
    output logic                   target_wr,
    output logic [15:0]            target_wdata,
    output logic                   busy,
    output logic                   soft_reset,
    output dws_pkg::dws_index_t    current_index
);
    import dws_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic dws_word_t mk(input logic [7:0] adr, input logic [2:0] wid,
                                     input logic [3:0] lsb, input logic [7:0] dat,
                                     input logic [3:0] dly, input logic eos);
        mk = {eos, dly, wid, lsb, adr, dat};
    endfunction

    function automatic dws_word_t rom_word(input dws_index_t i);
        case (i)
            6'h00: rom_word = mk(8'h04, 3'h4, 4'h0, 8'h1A, 4'h0, 1'b0);
            6'h01: rom_word = mk(8'h05, 3'h7, 4'h0, 8'h47, 4'h6, 1'b0);
            6'h02: rom_word = mk(8'h05, 3'h1, 4'h1, 8'h01, 4'h0, 1'b0);
            6'h03: rom_word = mk(8'h04, 3'h0, 4'h0, 8'h01, 4'h0, 1'b0);
            6'h04: rom_word = mk(8'h0E, 3'h1, 4'h0, 8'h03, 4'h0, 1'b0);
            6'h05: rom_word = mk(8'h0F, 3'h1, 4'h0, 8'h03, 4'h0, 1'b0);
            6'h06: rom_word = mk(8'h16, 3'h0, 4'h1, 8'h01, 4'h0, 1'b0);
            6'h07: rom_word = mk(8'h12, 3'h1, 4'h2, 8'h03, 4'h5, 1'b0);
            6'h09: rom_word = mk(8'h04, 3'h0, 4'h4, 8'h00, 4'h0, 1'b0);
            6'h0A: rom_word = mk(8'h62, 3'h0, 4'h0, 8'h01, 4'h6, 1'b0);
            6'h0C: rom_word = mk(8'h5A, 3'h7, 4'h0, 8'h11, 4'h0, 1'b0);
            6'h0D: rom_word = mk(8'h5E, 3'h7, 4'h0, 8'h11, 4'h0, 1'b0);
            6'h0E: rom_word = mk(8'h5A, 3'h7, 4'h0, 8'h33, 4'h0, 1'b0);
            6'h0F: rom_word = mk(8'h5E, 3'h7, 4'h0, 8'h33, 4'h0, 1'b0);
            6'h10: rom_word = mk(8'h43, 3'h3, 4'h0, 8'h0F, 4'hC, 1'b0);
            6'h11: rom_word = mk(8'h44, 3'h7, 4'h0, 8'hF0, 4'h0, 1'b0);
            6'h13: rom_word = mk(8'h5A, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0);
            6'h14: rom_word = mk(8'h5E, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0);
            6'h15: rom_word = mk(8'h5A, 3'h7, 4'h0, 8'hFF, 4'h0, 1'b0);
            6'h16: rom_word = mk(8'h5E, 3'h7, 4'h0, 8'hFF, 4'h0, 1'b1);
            6'h19: rom_word = mk(8'h5E, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0);
            6'h1A: rom_word = mk(8'h5A, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0);
            6'h1B: rom_word = mk(8'h5A, 3'h7, 4'h0, 8'h00, 4'h0, 1'b0);
            6'h1C: rom_word = mk(8'h5E, 3'h7, 4'h0, 8'h00, 4'h0, 1'b0);
            6'h1D: rom_word = mk(8'h43, 3'h3, 4'h0, 8'h00, 4'h0, 1'b0);
            6'h1E: rom_word = mk(8'h62, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0);
            6'h1F: rom_word = mk(8'h12, 3'h1, 4'h2, 8'h00, 4'h0, 1'b0);
            6'h20: rom_word = mk(8'h16, 3'h0, 4'h1, 8'h00, 4'h0, 1'b0);
            6'h21: rom_word = mk(8'h0E, 3'h1, 4'h0, 8'h00, 4'h0, 1'b0);
            6'h22: rom_word = mk(8'h0F, 3'h1, 4'h0, 8'h00, 4'h0, 1'b0);
            6'h23: rom_word = mk(8'h04, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0);
            6'h24: rom_word = mk(8'h05, 3'h0, 4'h0, 8'h00, 4'hC, 1'b0);
            6'h25: rom_word = mk(8'h05, 3'h0, 4'h0, 8'h00, 4'h9, 1'b0);
            6'h26: rom_word = mk(8'h05, 3'h7, 4'h0, 8'h00, 4'h0, 1'b0);
            6'h27: rom_word = mk(8'h04, 3'h1, 4'h0, 8'h00, 4'h0, 1'b1);
            // steps 8, 11, 18, 23, 24 and anything unlisted
            default: rom_word = mk(`DWS_DUMMY_ADDR, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // writable steps; sys_rst models power-on reset, R0 is not a reset here
    dws_word_t  ram [0:31];
    logic       ram_loaded;

    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_ram
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    ram[g] <= rom_word(6'(g));
                end else if (step_wr && step_index == 6'(g)) begin
                    ram[g] <= step_word;
                end
            end
        end
    endgenerate

    function automatic dws_word_t word_at(input dws_index_t i);
        word_at = (i <= `DWS_RAM_LAST) ? ram[i[4:0]] : rom_word(i);
    endfunction

    dws_word_t cur;
    dws_word_t launch_word;
    dws_word_t following_word;
    assign cur            = word_at(current_index);
    assign launch_word    = word_at(host_data[5:0]);
    assign following_word = word_at(current_index + 6'h01);

    ////////////////////////////////////////////////////////////////////////////////
    dws_tick_if tk ();
    dws_tick u_tick (
        .clock   (clock),
        .sys_rst (sys_rst),
        .tk      (tk)
    );

    dws_state_e  state;
    logic [15:0] units_left;
    logic        launch;
    logic [3:0]  dly;
    logic [15:0] fmask;
    logic [15:0] fdata;
    logic [15:0] step_units;

    // host write of the launch register with bit 8 set; low six bits are the start index
    assign launch = host_wr && host_addr == `DWS_LAUNCH_ADDR && host_data[8];
    assign dly    = cur[`DWS_F_DLY_HI:`DWS_F_DLY_LO];
    assign step_units = (16'h0001 << dly) + 16'(`DWS_DELAY_BIAS);
    // field mask built at 16 bits so lsb+width past bit 15 just truncates
    assign fmask = 16'((16'h01FF >> (3'h7 - cur[`DWS_F_WID_HI:`DWS_F_WID_LO]) >> 1)
                       << cur[`DWS_F_LSB_HI:`DWS_F_LSB_LO]);
    assign fdata = 16'({8'h00, cur[`DWS_F_DAT_HI:`DWS_F_DAT_LO]}
                       << cur[`DWS_F_LSB_HI:`DWS_F_LSB_LO]);
    // counter restarts on the edge that issues a step's read
    assign tk.run = (state == DWS_WRITE) ||
                    (state == DWS_WAIT && !(tk.tick && units_left == 16'h0001));

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state         <= DWS_IDLE;
            current_index <= 6'h00;
            units_left    <= 16'h0000;
            busy          <= 1'b0;
            target_rd     <= 1'b0;
            target_wr     <= 1'b0;
            target_wdata  <= 16'h0000;
            target_register_index <= 8'h00;
        end else begin
            target_wr <= 1'b0;
            target_rd <= 1'b0;
            case (state)
                DWS_IDLE: begin
                    if (launch && host_data[5:0] < 6'(`DWS_STEP_COUNT)) begin
                        current_index <= host_data[5:0];
                        busy          <= 1'b1;
                        state         <= DWS_WRITE;
                        target_rd     <= 1'b1;
                        target_register_index <= launch_word[`DWS_F_ADR_HI:`DWS_F_ADR_LO];
                    end
                end
                DWS_WRITE: begin
                    // read-modify-write keeps bits outside the field
                    target_register_index <= cur[`DWS_F_ADR_HI:`DWS_F_ADR_LO];
                    if (target_rd) begin
                        target_rd <= 1'b0;
                        target_wr <= 1'b0;
                    end
                    if (!target_rd && !target_wr) begin
                        target_rd <= 1'b1;
                    end else if (target_rd) begin
                        target_wdata <= (target_rdata & ~fmask) | (fdata & fmask);
                        target_wr    <= 1'b1;
                        units_left   <= step_units;
                        state        <= DWS_WAIT;
                    end
                end
                DWS_WAIT: begin
                    if (tk.tick) begin
                        if (units_left == 16'h0001) begin
                            if (cur[`DWS_F_EOS] || current_index == 6'h27) begin
                                busy  <= 1'b0;
                                state <= DWS_IDLE;
                            end else begin
                                current_index <= current_index + 6'h01;
                                state         <= DWS_WRITE;
                                target_rd     <= 1'b1;
                                target_register_index <=
                                    following_word[`DWS_F_ADR_HI:`DWS_F_ADR_LO];
                            end
                        end
                        units_left <= units_left - 16'h0001;
                    end
                end
                default: state <= DWS_IDLE;
            endcase
        end
    end

    // software reset strobe passes out; step storage is untouched by it
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= host_wr && host_addr == `DWS_SOFT_RESET_ADDR;
        end
    end
endmodule

// *** shared/dws_map.svh ***
`ifndef DWS_MAP_SVH
`define DWS_MAP_SVH
// sequencer launch register and launch values
`define DWS_LAUNCH_ADDR      8'h6F
`define DWS_LAUNCH_STARTUP   16'h0100
`define DWS_LAUNCH_SHUTDOWN  16'h0119
`define DWS_SOFT_RESET_ADDR  8'h00
`define DWS_DUMMY_ADDR       8'hFF
// step indices
`define DWS_STARTUP_FIRST    6'h00
`define DWS_STARTUP_LAST     6'h16
`define DWS_SHUTDOWN_FIRST   6'h19
`define DWS_SHUTDOWN_LAST    6'h27
`define DWS_RAM_LAST         6'h1F
`define DWS_STEP_COUNT       40
// step word layout: eos[27] delay[26:23] width[22:20] lsb[19:16] addr[15:8] data[7:0]
`define DWS_F_EOS            27
`define DWS_F_DLY_HI         26
`define DWS_F_DLY_LO         23
`define DWS_F_WID_HI         22
`define DWS_F_WID_LO         20
`define DWS_F_LSB_HI         19
`define DWS_F_LSB_LO         16
`define DWS_F_ADR_HI         15
`define DWS_F_ADR_LO         8
`define DWS_F_DAT_HI         7
`define DWS_F_DAT_LO         0
// delay unit 62.5 us, kept in ns
`define DWS_UNIT_NS          62500
`define DWS_CLK_NS           8
`define DWS_UNIT_CYCLES      (`DWS_UNIT_NS / `DWS_CLK_NS)
`define DWS_DELAY_BIAS       8
`endif

// *** shared/dws_pkg.sv ***
package dws_pkg;
    typedef logic [5:0]  dws_index_t;
    typedef logic [27:0] dws_word_t;
    typedef enum logic [1:0] {
        DWS_IDLE,
        DWS_WRITE,
        DWS_WAIT
    } dws_state_e;
endpackage

// *** shared/dws_tick_if.sv ***
`timescale 1ns/1ps
interface dws_tick_if;
    logic run;
    logic tick;
    modport ctl (output run, input tick);
    modport gen (input run, output tick);
endinterface

// *** rtl/dws_tick.sv ***
`timescale 1ns/1ps
`include "dws_map.svh"
module dws_tick (
    input  wire logic clock,
    input  wire logic sys_rst,
    dws_tick_if.gen   tk
);
    import dws_pkg::*;
    localparam logic [12:0] TICK_LAST = 13'(`DWS_UNIT_CYCLES - 1);
    logic [12:0] cnt;

    // restart phase on each run so every step gets full units
    always_ff @(posedge clock) begin
        if (sys_rst || !tk.run) begin
            cnt <= 13'h0000;
        end else if (cnt == TICK_LAST) begin
            cnt <= 13'h0000;
        end else begin
            cnt <= cnt + 13'h0001;
        end
    end

    // decoded from the counter so a step ends on the unit boundary, not one late
    assign tk.tick = (cnt == TICK_LAST);
endmodule

// *** testbench/dws_seq_sva.sv ***
`timescale 1ns/1ps
module dws_seq_sva (
    input wire logic                clock,
    input wire logic                sys_rst,
    input wire logic                host_wr,
    input wire logic [7:0]          host_addr,
    input wire logic [15:0]         host_data,
    input wire logic                target_rd,
    input wire logic                target_wr,
    input wire logic                busy,
    input wire logic                soft_reset,
    input wire dws_pkg::dws_index_t current_index
);
    import dws_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic [16:0] gap;
    logic        seen;
    always_ff @(posedge clock) begin
        if (sys_rst || !busy) seen <= 1'b0;
        else if (target_rd) seen <= 1'b1;
    end
    // saturates so an idle spell never wraps into a false short gap
    always_ff @(posedge clock) begin
        if (target_rd) gap <= 17'h00000;
        else if (gap != 17'h1FFFF) gap <= gap + 17'h00001;
    end
    launch_start_a: assert property (host_wr && host_addr == 8'h6F && host_data[8]
        && !busy && host_data[5:0] < 6'h28 |=> busy && target_rd
        && current_index == $past(host_data[5:0])) else $error("launch not taken");
    rd_then_wr_a: assert property (target_rd |=> target_wr && !target_rd)
        else $error("write does not follow read");
    wr_has_rd_a: assert property (target_wr |-> $past(target_rd))
        else $error("write without read");
    // shortest step is nine units of 7812 cycles
    step_spacing_a: assert property (target_rd && seen |-> gap >= 17'h112A3)
        else $error("step too short");
    rd_in_run_a: assert property (target_rd |-> busy)
        else $error("step outside a run");
    soft_pulse_a: assert property (host_wr && host_addr == 8'h00 |=> soft_reset)
        else $error("soft reset missing");
    soft_cause_a: assert property (soft_reset |-> $past(host_wr && host_addr == 8'h00))
        else $error("stray soft reset");
    index_range_a: assert property (busy |-> current_index <= 6'h27)
        else $error("index past last step");
    quiet_release_a: assert property ($past(sys_rst) |-> !busy && !target_rd)
        else $error("activity right after reset");
    idle_quiet_a: assert property (!busy |-> !target_wr)
        else $error("write while idle");
    c_launch: cover property (target_rd && current_index == 6'h00);
    c_shut: cover property (target_rd && current_index == 6'h19);
    c_gap: cover property (target_rd && seen);
endmodule
bind dws_sequencer dws_seq_sva chk (.clock(clock), .sys_rst(sys_rst), .host_wr(host_wr),
    .host_addr(host_addr), .host_data(host_data), .target_rd(target_rd),
    .target_wr(target_wr), .busy(busy), .soft_reset(soft_reset),
    .current_index(current_index));

// *** testbench/dws_host_regs.sv ***
`timescale 1ns/1ps
module dws_host_regs (
    input  wire logic        clock,
    input  wire logic [7:0]  target_register_index,
    input  wire logic        target_wr,
    input  wire logic [15:0] target_wdata,
    output logic      [15:0] target_rdata
);
    logic [15:0] regs [0:254];
    // mixed pattern so kept bits differ from written ones
    initial for (int i = 0; i < 255; i++) regs[i] = 16'hA5C3;
    always @(posedge clock) begin
        if (target_wr && target_register_index != 8'hFF) begin
            regs[target_register_index] <= target_wdata;
        end
    end
    assign target_rdata = (target_register_index == 8'hFF) ? 16'h5A3C
                          : regs[target_register_index];
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
    import dws_pkg::*;
    logic clock, sys_rst, host_wr, step_wr, target_rd, target_wr, busy, soft_reset;
    logic [7:0]  host_addr, target_register_index;
    logic [15:0] host_data, target_rdata, target_wdata;
    dws_index_t  step_index, current_index;
    dws_word_t   step_word;
    int error_cnt, num_checks, cyc, t0;
    logic [15:0] rd;
    dws_sequencer DUT (.clock(clock), .sys_rst(sys_rst), .host_wr(host_wr),
        .host_addr(host_addr), .host_data(host_data), .step_wr(step_wr),
        .step_index(step_index), .step_word(step_word), .target_rdata(target_rdata),
        .target_register_index(target_register_index), .target_rd(target_rd),
        .target_wr(target_wr), .target_wdata(target_wdata), .busy(busy),
        .soft_reset(soft_reset), .current_index(current_index));
    dws_host_regs host (.clock(clock), .target_register_index(target_register_index),
        .target_wr(target_wr), .target_wdata(target_wdata), .target_rdata(target_rdata));
    always #4 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        if (error_cnt == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
    endtask
    task automatic host_write(input logic [7:0] a, input logic [15:0] d);
        host_wr <= 1'b1;
        host_addr <= a;
        host_data <= d;
        @(posedge clock);
        host_wr <= 1'b0;
    endtask
    // launch, then judge the first step's read and merged write
    task automatic run_first(input logic [15:0] d, input logic [7:0] adr,
                             input logic [15:0] m, input logic [15:0] v);
        host_write(8'h6F, d);
        #1;
        t0 = cyc;
        check("busy", busy, 1);
        check("read strobe", target_rd, 1);
        check("index", current_index, d[5:0]);
        check("register", target_register_index, adr);
        rd = target_rdata;
        @(posedge clock);
        #1;
        check("write strobe", target_wr, 1);
        check("merged value", target_wdata, (rd & ~m) | v);
    endtask
    task automatic startup_run;
        run_first(16'h0100, 8'h04, 16'h001F, 16'h001A);
        host_write(8'h6F, 16'h0119);
        @(posedge clock);
        host_write(8'h00, 16'h0000);
        #1;
        check("soft reset", soft_reset, 1);
        check("index kept", current_index, 0);
        step_wr <= 1'b1;
        step_index <= 6'h01;
        step_word <= 28'h8130F02;
        @(posedge clock);
        step_index <= 6'h12;
        step_word <= 28'h000FF00;
        @(posedge clock);
        step_wr <= 1'b0;
        while (target_rd !== 1'b1 && cyc - t0 < 80000) begin
            @(posedge clock);
            #1;
        end
        check("step spacing", cyc - t0, 70308);
        check("register", target_register_index, 8'h0F);
        rd = target_rdata;
        @(posedge clock);
        #1;
        check("merged value", target_wdata, (rd & 16'hFFE7) | 16'h0010);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 0;
        sys_rst = 1;
        {host_wr, step_wr, host_addr, host_data, step_index, step_word} = '0;
        do_reset;
        run_first(16'h0119, 8'h5E, 16'h00FF, 16'h0077);
        do_reset;
        run_first(16'h011A, 8'h5A, 16'h00FF, 16'h0077);
        do_reset;
        startup_run;
        do_reset;
        run_first(16'h0101, 8'h05, 16'h00FF, 16'h0047);
        conclude;
    end
    // one full step plus margin
    initial begin
        repeat (90000) @(posedge clock);
        error_cnt++;
        conclude;
    end
endmodule
